// *** bench/agu_properties.sv ***
// concurrent checks on the address generator ports
module agu_properties
  import agu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // watched inputs
  input wire logic clk_en_i,
  input agu_pkg::agu_req_t req_i,
  input wire logic sp_we_i,
  // watched outputs
  input agu_pkg::agu_rsp_t rsp_o,
  input wire logic [15:0] stack_ptr_o,
  input wire logic stack_trap_o,
  input wire logic access_denied_o,
  input wire logic mac_fault_o
);
  logic take;
  assign take = clk_en_i && req_i.valid && !sp_we_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  chk_push_next_free: assert property (
    take && req_i.kind == OP_PUSH |=> rsp_o.ea == $past(stack_ptr_o) &&
    (access_denied_o || stack_ptr_o == $past(stack_ptr_o) + WORD_STEP))
    else $error("push address or pointer step wrong");
  chk_pop_pre_dec: assert property (
    take && req_i.kind == OP_POP |=> rsp_o.ea == $past(stack_ptr_o) - 16'h0002)
    else $error("pop address not decremented first");
  chk_call_msb_clear: assert property (
    take && req_i.kind == OP_CALL_PUSH && req_i.hi_half |=>
    rsp_o.push_data == {9'h000, $past(req_i.pc[22:16])})
    else $error("call upper word not zero extended");
  chk_exc_status_join: assert property (
    take && req_i.kind == OP_EXC_PUSH && req_i.hi_half |=> rsp_o.push_data
    == {$past(req_i.status_low_byte), 1'b0, $past(req_i.pc[22:16])})
    else $error("exception upper word wrong");
  chk_trap_floor: assert property (
    take && req_i.kind == OP_POP &&
    stack_ptr_o inside {[16'h0002:16'h0801]} |=> stack_trap_o)
    else $error("pop below floor gave no trap");
  chk_trap_pulse: assert property (
    stack_trap_o |-> rsp_o.valid)
    else $error("trap without its answer");
  chk_file_near: assert property (
    take && req_i.kind == OP_FILE_REG |=>
    rsp_o.ea == {3'h0, $past(req_i.file_addr)})
    else $error("file register address wrong");
  chk_mac_bad_reg: assert property (
    take && req_i.kind == OP_MAC && !(req_i.ptr_sel inside {[4'h8:4'hB]})
    |=> mac_fault_o && !rsp_o.mem_en)
    else $error("illegal prefetch register accepted");
  chk_mac_y_word: assert property (
    take && req_i.kind == OP_MAC && req_i.ptr_sel inside {4'hA, 4'hB} &&
    req_i.mode != AM_INDEXED |=> rsp_o.space_y && !rsp_o.ea[0])
    else $error("y prefetch space or alignment wrong");
  chk_irq_disable_instr_unsigned: assert property (
    take && req_i.kind == OP_IRQ_DISABLE_INSTR |=>
    rsp_o.operand == {2'h0, $past(req_i.literal[13:0])})
    else $error("disable literal not 14-bit unsigned");
  chk_denied_blocks: assert property (
    access_denied_o |-> !rsp_o.mem_en && !rsp_o.push_en)
    else $error("denied access still reaches memory");
endmodule // agu_properties

// *** bench/data_address_generation_unit_tb_top.sv ***
// self-checking bench for the data address generator
module data_address_generation_unit_tb_top
  import agu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  agu_req_t req_i = '0;
  circ_cfg_t circ_i = '0;
  sec_cfg_t sec_i = '0;
  logic sp_we_i = 1'b0;
  logic [15:0] sp_data_i = 16'h0000;
  logic limit_we_i = 1'b0;
  logic [15:0] limit_data_i = 16'h0000;
  agu_rsp_t rsp_o;
  logic [15:0] stack_ptr_o;
  logic stack_trap_o, access_denied_o, mac_fault_o;
  int error_cnt = 0;
  int checks = 0;
  int seed = 62385;
  int sp_m, lim_m;
  logic [15:0] stk [$];
  agu_req_t r;
  logic [15:0] p, b, l;

  always #5 clk_sys_i = ~clk_sys_i;

  data_address_generation_unit u_dut (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .req_i(req_i),
    .circ_i(circ_i), .sec_i(sec_i), .sp_we_i(sp_we_i),
    .sp_data_i(sp_data_i), .limit_we_i(limit_we_i),
    .limit_data_i(limit_data_i), .rsp_o(rsp_o), .stack_ptr_o(stack_ptr_o),
    .stack_trap_o(stack_trap_o), .access_denied_o(access_denied_o),
    .mac_fault_o(mac_fault_o));
  data_mem_model u_mem (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .rsp_i(rsp_o));

  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic agu_req_t mk(input op_kind_t k, input addr_mode_t m,
    input logic [3:0] s, input logic [15:0] v, input logic [15:0] t);
    mk = '0;
    mk.valid = 1'b1;
    mk.kind = k;
    mk.mode = m;
    mk.ptr_sel = s;
    mk.ptr_val = v;
    mk.literal = t;
  endfunction

  // request taken one edge later, answer stands one cycle
  task automatic send(input agu_req_t q);
    @(posedge clk_sys_i);
    req_i <= q;
    @(posedge clk_sys_i);
    req_i.valid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [15:0] s, input logic [15:0] t);
    @(posedge clk_sys_i);
    sp_we_i <= 1'b1;
    sp_data_i <= s;
    limit_we_i <= 1'b1;
    limit_data_i <= t;
    @(posedge clk_sys_i);
    sp_we_i <= 1'b0;
    limit_we_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    sp_m = s & 16'hFFFE;
    lim_m = t & 16'hFFFE;
    cmp("sp write", sp_m[15:0], stack_ptr_o);
  endtask

  task automatic stk_op(input logic push, input logic [15:0] d);
    int ea;
    ea = push ? sp_m : sp_m - 2;
    send(mk(push ? OP_PUSH : OP_POP, AM_INDIRECT, SP_IDX, 16'h0000, d));
    cmp("stack ea", ea[15:0], rsp_o.ea);
    cmp("trap", 16'(ea > lim_m || ea < 'h800), 16'(stack_trap_o));
    sp_m = push ? sp_m + 2 : ea;
    cmp("sp", sp_m[15:0], stack_ptr_o);
    if (push)
    begin
      cmp("push data", d, rsp_o.push_data);
      stk.push_back(d);
    end
    else if (stk.size() > 0)
      cmp("popped", stk.pop_back(), u_mem.peek(rsp_o.ea));
  endtask

  task automatic pc_push(input op_kind_t k);
    agu_req_t q;
    q = mk(k, AM_INDIRECT, SP_IDX, 16'h0000, 16'h0000);
    q.pc = 23'($random(seed));
    q.status_low_byte = 8'($random(seed));
    send(q);
    cmp("pc low", q.pc[15:0], rsp_o.push_data);
    q.hi_half = 1'b1;
    send(q);
    cmp("pc high", {k == OP_EXC_PUSH ? q.status_low_byte : 8'h00, 1'b0,
      q.pc[22:16]}, rsp_o.push_data);
    sp_m += 4;
    cmp("sp", sp_m[15:0], stack_ptr_o);
  endtask

  task automatic circ(input logic [15:0] c, input logic [15:0] v,
    input logic [15:0] t, input logic [15:0] e);
    @(posedge clk_sys_i);
    circ_i.circ_addr_control <= c;
    send(mk(OP_THREE, AM_POST_MOD, 4'h2, v, t));
    cmp("circ wb", e, rsp_o.wb_val);
  endtask

  task automatic sec(input code_seg_t g, input logic [15:0] v, input logic d);
    r = mk(OP_THREE, AM_INDIRECT, 4'h3, v, 16'h0000);
    r.code_seg = g;
    send(r);
    cmp("denied", 16'(d), 16'(access_denied_o));
    cmp("mem en", 16'(!d), 16'(rsp_o.mem_en));
  endtask

  initial
  begin
    #500000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1;
    cmp("sp reset", SP_RESET, stack_ptr_o);
    wr(16'h0901, 16'h0905);
    repeat (4) stk_op(1'b1, 16'($random(seed)));
    repeat (5) stk_op(1'b0, 16'h0000);
    wr(16'h0800, 16'h0905);
    stk_op(1'b0, 16'h0000);
    $display("stack test done");
    wr(16'h0A00, 16'h0FFE);
    pc_push(OP_CALL_PUSH);
    pc_push(OP_EXC_PUSH);
    $display("counter push test done");
    for (int i = 1; i < 7; i++)
    begin
      p = 16'($random(seed));
      b = 16'($random(seed));
      l = 16'($random(seed));
      r = mk(OP_THREE, addr_mode_t'(i), 4'h3, p, l);
      r.base_val = b;
      send(r);
      if (i < 6)
        cmp("mode ea", i == 1 || i == 2 ? p : i == 4 ? p + b : p + l,
          rsp_o.ea);
      if (i == 2 || i == 3)
        cmp("mode wb", p + l, rsp_o.wb_val);
      cmp("operand", i == 6 ? {11'h000, l[4:0]} : b, rsp_o.operand);
    end
    $display("mode test done");
    for (int q = 7; q < 13; q++)
    begin
      p = 16'($random(seed)) | 16'h0001;
      r = mk(OP_MAC, AM_POST_MOD, 4'(q), p, 16'h0000);
      r.mac_step = 2'(1 + q % 3);
      send(r);
      cmp("mac fault", 16'(q < 8 || q > 11), 16'(mac_fault_o));
      if (q == 8 || q == 9)
        cmp("mac wb", p + 16'(2 * (1 + q % 3)), rsp_o.wb_val);
      if (q == 10 || q == 11)
        cmp("mac y ea", p & 16'hFFFE, rsp_o.ea);
      r.mode = AM_INDEXED;
      send(r);
      cmp("index fault", 16'(q != 9 && q != 11), 16'(mac_fault_o));
    end
    $display("prefetch test done");
    r = mk(OP_FILE_REG, AM_DIRECT, 4'h0, 16'h0000, 16'h0000);
    r.file_addr = 13'($random(seed));
    send(r);
    cmp("file ea", {3'h0, r.file_addr}, rsp_o.ea);
    cmp("file dst", 16'(DEFAULT_WORK_REG_IDX), 16'(rsp_o.dst_sel));
    l = 16'($random(seed));
    send(mk(OP_BRANCH, AM_LITERAL, 4'h0, 16'h0000, l));
    cmp("branch", l, rsp_o.operand);
    send(mk(OP_IRQ_DISABLE_INSTR, AM_LITERAL, 4'h0, 16'h0000, l));
    cmp("disable", {2'h0, l[13:0]}, rsp_o.operand);
    $display("literal test done");
    circ_i.x_circ_start <= 16'h1000;
    circ_i.x_circ_end <= 16'h101F;
    circ(16'h8002, 16'h101E, 16'h0004, 16'h1002);
    circ(16'h800F, 16'h101E, 16'h0004, 16'h1022);
    circ(16'h8002, 16'h1000, 16'hFFFC, 16'h101C);
    $display("circular test done");
    sec_i.boot_secure_ram_en <= 1'b1;
    sec_i.boot_secure_ram_lo <= 16'h1200;
    sec_i.boot_secure_ram_hi <= 16'h12FF;
    sec_i.secure_segment_ram_en <= 1'b1;
    sec_i.secure_segment_ram_lo <= 16'h1400;
    sec_i.secure_segment_ram_hi <= 16'h14FF;
    sec(SEG_GENERAL, 16'h1210, 1'b1);
    sec(SEG_BOOT, 16'h1210, 1'b0);
    sec(SEG_BOOT, 16'h1410, 1'b1);
    sec(SEG_SECURE, 16'h1410, 1'b0);
    $display("secure test done");
    final_report();
  end
endmodule // data_address_generation_unit_tb_top

bind data_address_generation_unit agu_properties u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
  .req_i(req_i), .sp_we_i(sp_we_i), .rsp_o(rsp_o),
  .stack_ptr_o(stack_ptr_o), .stack_trap_o(stack_trap_o),
  .access_denied_o(access_denied_o), .mac_fault_o(mac_fault_o));

// *** bench/data_mem_model.sv ***
// data memory stand-in: records pushed words by address
module data_mem_model
  import agu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // answer from the generator
  input agu_pkg::agu_rsp_t rsp_i
);
  logic [15:0] mem [logic [15:0]];
  // sample mid-cycle, where the registered answer is settled
  always @(negedge clk_sys_i)
  begin
    if (reset_n_i && rsp_i.valid && rsp_i.mem_en && rsp_i.push_en)
      mem[rsp_i.ea] = rsp_i.push_data;
  end
  // unwritten words read back as a marker pattern
  function automatic logic [15:0] peek(input logic [15:0] a);
    peek = mem.exists(a) ? mem[a] : ~a;
  endfunction
endmodule // data_mem_model

// *** common/agu_pkg.sv ***
// shared constants and carrier types for the data address generator
package agu_pkg;

  localparam logic [15:0] SFR_FLOOR = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] CIRC_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] DEFAULT_WORK_REG_IDX = 4'h0;
  localparam logic [3:0] SP_IDX = 4'hF;
  localparam logic [3:0] CIRC_OFF_SEL = 4'hF;
  localparam logic [3:0] X_PREFETCH_A = 4'h8;
  localparam logic [3:0] X_PREFETCH_B = 4'h9;
  localparam logic [3:0] Y_PREFETCH_A = 4'hA;
  localparam logic [3:0] Y_PREFETCH_B = 4'hB;
  localparam int X_EN_POS = 15;
  localparam int Y_EN_POS = 14;
  localparam int X_SEL_LSB = 0;
  localparam int Y_SEL_LSB = 4;
  localparam int NEAR_W = 13;
  localparam int SHORT_LIT_W = 5;
  localparam int IRQ_DISABLE_INSTR_LIT_W = 14;
  localparam int PC_W = 23;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_FILE_REG = 4'b0001,
    OP_THREE = 4'b0010,
    OP_MOVE = 4'b0011,
    OP_MAC = 4'b0100,
    OP_BRANCH = 4'b0101,
    OP_IRQ_DISABLE_INSTR = 4'b0110,
    OP_PUSH = 4'b0111,
    OP_POP = 4'b1000,
    OP_CALL_PUSH = 4'b1001,
    OP_EXC_PUSH = 4'b1010
  } op_kind_t;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'b000,
    AM_INDIRECT = 3'b001,
    AM_POST_MOD = 3'b010,
    AM_PRE_MOD = 3'b011,
    AM_INDEXED = 3'b100,
    AM_LIT_OFFSET = 3'b101,
    AM_LITERAL = 3'b110
  } addr_mode_t;

  typedef enum logic [1:0] {
    SEG_GENERAL = 2'b00,
    SEG_BOOT = 2'b01,
    SEG_SECURE = 2'b10
  } code_seg_t;

  typedef struct packed {
    logic valid;
    op_kind_t kind;
    addr_mode_t mode;
    logic [3:0] ptr_sel;
    logic [15:0] ptr_val;
    logic [3:0] base_sel;
    logic [15:0] base_val;
    logic [15:0] literal;
    logic [NEAR_W-1:0] file_addr;
    logic dst_default_work_reg;
    logic is_mul;
    logic [1:0] mac_step;
    logic mac_dec;
    logic hi_half;
    logic [PC_W-1:0] pc;
    logic [7:0] status_low_byte;
    code_seg_t code_seg;
  } agu_req_t;

  typedef struct packed {
    logic [15:0] x_circ_start;
    logic [15:0] x_circ_end;
    logic [15:0] y_circ_start;
    logic [15:0] y_circ_end;
    logic [15:0] circ_addr_control;
  } circ_cfg_t;

  typedef struct packed {
    logic boot_secure_ram_en;
    logic [15:0] boot_secure_ram_lo;
    logic [15:0] boot_secure_ram_hi;
    logic secure_segment_ram_en;
    logic [15:0] secure_segment_ram_lo;
    logic [15:0] secure_segment_ram_hi;
  } sec_cfg_t;

  typedef struct packed {
    logic valid;
    logic mem_en;
    logic space_y;
    logic [15:0] ea;
    logic wb_en;
    logic [3:0] wb_sel;
    logic [15:0] wb_val;
    logic dst_en;
    logic [3:0] dst_sel;
    logic [15:0] operand;
    logic push_en;
    logic [15:0] push_data;
  } agu_rsp_t;

endpackage

// *** hdl/circ_wrap.sv ***
// circular buffer boundary check and wrap for one address space
module circ_wrap
(
  // configuration
  input wire logic enable_i,
  input wire logic [15:0] start_i,
  input wire logic [15:0] end_i,
  input wire logic word_only_i,
  // address in and out
  input wire logic incr_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] addr_o
);

  logic [16:0] len;
  logic pow2;
  logic over;
  logic under;

  always_comb
  begin
    // length is end minus start plus one, at most a full 64 KB space
    len = {1'b0, end_i} - {1'b0, start_i} + 17'h00001; // [R21]
    pow2 = ((len & (len - 17'h00001)) == 17'h00000);
    // compare with less/greater so that large steps still wrap
    over = (addr_i > end_i) && (incr_i || pow2); // [R20] [R24]
    under = (addr_i < start_i) && (!incr_i || pow2); // [R20] [R24]
    addr_o = addr_i;
    if (enable_i && over)
    begin
      addr_o = addr_i - len[15:0];
    end
    else if (enable_i && under)
    begin
      addr_o = addr_i + len[15:0];
    end
    if (word_only_i)
    begin
      addr_o[0] = 1'b0; // [R22]
    end
  end

endmodule // circ_wrap

// *** hdl/data_address_generation_unit.sv ***
// effective address generation, software stack and circular buffers
//
// Notes on behaviour
// [R1] stack pointer names next free word, grows up
// [R2] pop decrements first; push writes then increments
// [R3] call push stores counter upper part, msb clear
// [R4] exception push joins status byte to upper counter
// [R5] limit has no reset; its bit 0 is zero
// [R6] stack address above limit raises stack trap
// [R7] stack address below floor raises stack trap
// [R8] software avoids stack read right after limit write
// [R9] secure ram segments only for matching code
// [R10] file register address is 13-bit near field
// [R11] default result register is register zero
// [R12] first operand direct register; second register/memory/literal
// [R13] indirect, post, pre, indexed, literal offset modes
// [R14] move shares one offset field for both ends
// [R15] prefetch only via 8..11, split x and y
// [R16] indexed prefetch only via 9 and 11
// [R17] prefetch post-modify by 2, 4 or 6
// [R18] branch signed 16-bit, disable unsigned 14-bit
// [R19] one circular buffer each in x and y
// [R20] one-way wrap unless length is power of two
// [R21] buffer length is end minus start plus one
// [R22] y circular addresses stay word aligned
// [R23] circular mode needs select not 15 and enable
// [R24] steps past a boundary still wrap correctly
// [R25] stack trap pulses with the offending address
module data_address_generation_unit
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // request from instruction decode
  input agu_pkg::agu_req_t req_i,
  // circular buffer and security configuration
  input agu_pkg::circ_cfg_t circ_i,
  input agu_pkg::sec_cfg_t sec_i,
  // stack pointer and limit writes
  input wire logic sp_we_i,
  input wire logic [15:0] sp_data_i,
  input wire logic limit_we_i,
  input wire logic [15:0] limit_data_i,
  // answer towards data memory and register file
  output agu_pkg::agu_rsp_t rsp_o,
  output logic [15:0] stack_ptr_o,
  output logic stack_trap_o,
  output logic access_denied_o,
  output logic mac_fault_o
);
  import agu_pkg::*;

  logic [15:0] stack_pointer_reg_q;
  logic [15:0] stack_pointer_reg_d;
  logic [15:0] stack_limit_reg_q;
  logic [15:0] stack_limit_reg_d;
  agu_rsp_t rsp_q;
  agu_rsp_t rsp_d;
  logic stack_trap_q;
  logic stack_trap_d;
  logic denied_q;
  logic denied_d;
  logic mac_fault_q;
  logic mac_fault_d;

  logic [15:0] raw_ea;
  logic [15:0] new_ptr;
  logic ptr_update;
  logic use_stack;
  logic space_y;
  logic circ_en;
  logic circ_incr;
  logic [15:0] circ_in;
  logic [15:0] circ_out;
  logic [15:0] circ_start;
  logic [15:0] circ_end;
  logic [3:0] ptr_sel;
  logic [15:0] ptr_val;
  logic [15:0] mac_mod;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic circ_on(input logic [3:0] sel,
                                   input logic en,
                                   input logic [3:0] ptr);
    circ_on = en && (sel != CIRC_OFF_SEL) && (sel == ptr); // [R23]
  endfunction

  // address arithmetic for the current request
  always_comb
  begin
    ptr_sel = req_i.ptr_sel;
    ptr_val = (req_i.ptr_sel == SP_IDX) ? stack_pointer_reg_q
                                        : req_i.ptr_val;
    raw_ea = ptr_val;
    new_ptr = ptr_val;
    ptr_update = 1'b0;
    use_stack = 1'b0;
    space_y = 1'b0;
    circ_incr = 1'b1;
    mac_mod = {13'h0000, req_i.mac_step, 1'b0}; // [R17]
    case (req_i.kind)
      OP_PUSH, OP_CALL_PUSH, OP_EXC_PUSH:
      begin
        ptr_sel = SP_IDX;
        raw_ea = stack_pointer_reg_q; // [R1] [R2]
        new_ptr = stack_pointer_reg_q + WORD_STEP; // [R2]
        ptr_update = 1'b1;
        use_stack = 1'b1;
      end
      OP_POP:
      begin
        ptr_sel = SP_IDX;
        raw_ea = stack_pointer_reg_q - WORD_STEP; // [R2]
        new_ptr = raw_ea;
        ptr_update = 1'b1;
        use_stack = 1'b1;
        circ_incr = 1'b0;
      end
      OP_FILE_REG:
      begin
        raw_ea = {3'b000, req_i.file_addr}; // [R10]
      end
      OP_MAC:
      begin
        space_y = (req_i.ptr_sel == Y_PREFETCH_A) ||
                  (req_i.ptr_sel == Y_PREFETCH_B); // [R15]
        if (req_i.mode == AM_INDEXED)
        begin
          raw_ea = ptr_val + req_i.base_val; // [R16]
        end
        else if (req_i.mode == AM_POST_MOD)
        begin
          new_ptr = req_i.mac_dec ? ptr_val - mac_mod
                                  : ptr_val + mac_mod; // [R17]
          ptr_update = 1'b1;
          circ_incr = !req_i.mac_dec;
        end
      end
      OP_THREE, OP_MOVE:
      begin
        use_stack = (req_i.ptr_sel == SP_IDX) &&
                    (req_i.mode != AM_DIRECT) &&
                    (req_i.mode != AM_LITERAL);
        case (req_i.mode)
          AM_POST_MOD:
          begin
            new_ptr = ptr_val + req_i.literal; // [R13]
            ptr_update = 1'b1;
            circ_incr = !req_i.literal[15];
          end
          AM_PRE_MOD:
          begin
            raw_ea = ptr_val + req_i.literal; // [R13]
            new_ptr = raw_ea;
            ptr_update = 1'b1;
            circ_incr = !req_i.literal[15];
          end
          AM_INDEXED:
          begin
            raw_ea = ptr_val + req_i.base_val; // [R13] [R14]
          end
          AM_LIT_OFFSET:
          begin
            raw_ea = ptr_val + req_i.literal; // [R13]
          end
          default:
          begin
            raw_ea = ptr_val; // [R13]
          end
        endcase
      end
      default:
      begin
        raw_ea = ptr_val;
      end
    endcase
    // one buffer per space; pick the one this access uses
    if (space_y)
    begin
      circ_en = circ_on(circ_i.circ_addr_control[Y_SEL_LSB+:4],
                        circ_i.circ_addr_control[Y_EN_POS], ptr_sel);
      circ_start = circ_i.y_circ_start;
      circ_end = circ_i.y_circ_end;
    end
    else
    begin
      circ_en = circ_on(circ_i.circ_addr_control[X_SEL_LSB+:4],
                        circ_i.circ_addr_control[X_EN_POS], ptr_sel);
      circ_start = circ_i.x_circ_start;
      circ_end = circ_i.x_circ_end;
    end
    circ_in = (ptr_update && req_i.mode != AM_PRE_MOD &&
               req_i.kind != OP_POP) ? new_ptr : raw_ea;
  end

  // applies to the pointer selected in the control word, never register 15
  circ_wrap u_circ_wrap // [R19]
  (
    .enable_i(circ_en && req_i.kind != OP_FILE_REG),
    .start_i(circ_start),
    .end_i(circ_end),
    .word_only_i(space_y),
    .incr_i(circ_incr),
    .addr_i(circ_in),
    .addr_o(circ_out)
  );

  // stack pointer and limit next values
  always_comb
  begin
    stack_pointer_reg_d = stack_pointer_reg_q;
    stack_limit_reg_d = stack_limit_reg_q;
    if (limit_we_i)
    begin
      stack_limit_reg_d = {limit_data_i[15:1], 1'b0}; // [R5]
    end
    if (req_i.valid && ptr_update && ptr_sel == SP_IDX &&
        req_i.kind != OP_MAC)
    begin
      stack_pointer_reg_d = {new_ptr[15:1], 1'b0}; // [R1]
    end
    if (sp_we_i)
    begin
      stack_pointer_reg_d = {sp_data_i[15:1], 1'b0};
    end
  end

  // answer next values
  always_comb
  begin
    logic [15:0] ea;
    logic [15:0] wb;
    logic fault;
    logic deny;
    ea = raw_ea;
    wb = new_ptr;
    fault = 1'b0;
    deny = 1'b0;
    rsp_d = '0;
    stack_trap_d = 1'b0;
    if (circ_en)
    begin
      if (req_i.mode == AM_POST_MOD && req_i.kind != OP_POP)
      begin
        wb = circ_out; // [R24]
      end
      else
      begin
        ea = circ_out; // [R24]
        wb = circ_out;
      end
    end
    if (req_i.kind == OP_MAC)
    begin
      fault = (req_i.ptr_sel < X_PREFETCH_A) ||
              (req_i.ptr_sel > Y_PREFETCH_B); // [R15]
      if (req_i.mode == AM_INDEXED &&
          req_i.ptr_sel != X_PREFETCH_B &&
          req_i.ptr_sel != Y_PREFETCH_B)
      begin
        fault = 1'b1; // [R16]
      end
      if (space_y)
      begin
        ea[0] = 1'b0; // [R22]
      end
    end
    if (sec_i.boot_secure_ram_en && req_i.code_seg != SEG_BOOT &&
        in_range(ea, sec_i.boot_secure_ram_lo, sec_i.boot_secure_ram_hi))
    begin
      deny = 1'b1; // [R9]
    end
    if (sec_i.secure_segment_ram_en && req_i.code_seg != SEG_SECURE &&
        in_range(ea, sec_i.secure_segment_ram_lo,
                 sec_i.secure_segment_ram_hi))
    begin
      deny = 1'b1; // [R9]
    end
    rsp_d.valid = req_i.valid;
    rsp_d.space_y = space_y;
    rsp_d.ea = ea;
    rsp_d.wb_sel = ptr_sel;
    rsp_d.wb_val = wb;
    rsp_d.wb_en = req_i.valid && ptr_update && !fault;
    case (req_i.kind)
      OP_FILE_REG:
      begin
        rsp_d.mem_en = 1'b1;
        rsp_d.dst_en = req_i.dst_default_work_reg || req_i.is_mul;
        rsp_d.dst_sel = req_i.is_mul ? req_i.base_sel : DEFAULT_WORK_REG_IDX; // [R11]
      end
      OP_THREE:
      begin
        rsp_d.operand = (req_i.mode == AM_LITERAL) ?
          {11'h000, req_i.literal[SHORT_LIT_W-1:0]} : // [R12]
          req_i.base_val; // [R12]
        rsp_d.mem_en = (req_i.mode != AM_DIRECT) &&
                       (req_i.mode != AM_LITERAL);
        rsp_d.dst_en = req_i.dst_default_work_reg;
        rsp_d.dst_sel = req_i.base_sel;
      end
      OP_MOVE:
      begin
        rsp_d.operand = req_i.literal;
        rsp_d.mem_en = (req_i.mode != AM_DIRECT) &&
                       (req_i.mode != AM_LITERAL);
      end
      OP_MAC:
      begin
        rsp_d.mem_en = !fault;
      end
      OP_BRANCH:
      begin
        rsp_d.operand = req_i.literal; // [R18]
      end
      OP_IRQ_DISABLE_INSTR:
      begin
        rsp_d.operand = {2'b00, req_i.literal[IRQ_DISABLE_INSTR_LIT_W-1:0]}; // [R18]
      end
      OP_PUSH, OP_CALL_PUSH, OP_EXC_PUSH:
      begin
        rsp_d.mem_en = 1'b1;
        rsp_d.push_en = 1'b1;
        rsp_d.push_data = req_i.literal;
        if (req_i.kind == OP_CALL_PUSH)
        begin
          rsp_d.push_data = req_i.hi_half ?
            {9'h000, req_i.pc[PC_W-1:16]} : // [R3]
            req_i.pc[15:0];
        end
        else if (req_i.kind == OP_EXC_PUSH)
        begin
          rsp_d.push_data = req_i.hi_half ?
            {req_i.status_low_byte, 1'b0, req_i.pc[PC_W-1:16]} : // [R4]
            req_i.pc[15:0];
        end
      end
      OP_POP:
      begin
        rsp_d.mem_en = 1'b1;
      end
      default:
      begin
        rsp_d.mem_en = 1'b0;
      end
    endcase
    if (req_i.valid && use_stack)
    begin
      // push at sp == limit passes; the following one traps
      stack_trap_d = (ea > stack_limit_reg_q) || // [R6] [R25]
                     (ea < SFR_FLOOR); // [R7] [R25]
    end
    rsp_d.mem_en = rsp_d.mem_en && req_i.valid && !deny;
    rsp_d.push_en = rsp_d.push_en && rsp_d.mem_en;
    denied_d = req_i.valid && deny;
    mac_fault_d = req_i.valid && fault;
  end

  // limit keeps no reset value
  always_ff @(posedge clk_sys_i)
  begin
    if (clk_en_i)
    begin
      stack_limit_reg_q <= stack_limit_reg_d; // [R5]
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stack_pointer_reg_q <= SP_RESET;
      rsp_q <= '0;
      stack_trap_q <= 1'b0;
      denied_q <= 1'b0;
      mac_fault_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      stack_pointer_reg_q <= stack_pointer_reg_d;
      rsp_q <= rsp_d;
      stack_trap_q <= stack_trap_d;
      denied_q <= denied_d;
      mac_fault_q <= mac_fault_d;
    end
  end

  assign rsp_o = rsp_q;
  assign stack_ptr_o = stack_pointer_reg_q;
  assign stack_trap_o = stack_trap_q;
  assign access_denied_o = denied_q;
  assign mac_fault_o = mac_fault_q;

endmodule // data_address_generation_unit
